// File: rtl/dca_input_stage.sv
// Command, address and clock-enable input stage of a DDR2 memory device
`default_nettype none
module dca_input_stage
    import dca_pkg::*;
#(
    parameter int ADDR_W = dca_pkg::ADDR_W_X8
) (
    // Core clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // Differential link clock and clock enable
    input  wire logic                  clock_true,
    input  wire logic                  clock_comp,
    input  wire logic                  clk_en,
    // Command and address pins
    input  wire logic                  chip_sel_n,
    input  wire logic                  row_strobe_n,
    input  wire logic                  col_strobe_n,
    input  wire logic                  write_en_n,
    input  wire logic [BANK_W-1:0]     bank_sel,
    input  wire logic [ADDR_W-1:0]     addr,
    input  wire logic                  termination_control,
    // Decoded command
    output var  logic                  cmd_valid,
    output var  dca_pkg::dca_cmd_t     cmd,
    output var  logic [BANK_W-1:0]     cmd_bank,
    output var  logic [ADDR_W-1:0]     cmd_row,
    output var  logic [ADDR_W-1:0]     cmd_col,
    output var  logic                  cmd_auto_pre,
    output var  logic                  cmd_all_banks,
    // Mode register load
    output var  logic                  mode_wr,
    output var  logic [1:0]            mode_sel,
    output var  logic [ADDR_W-1:0]     mode_opcode,
    // Bank and power state
    output var  logic [NUM_BANKS-1:0]  bank_open,
    output var  dca_pkg::dca_pwr_t     pwr_state,
    output var  logic                  int_clk_en,
    output var  logic                  cmd_rx_en,
    output var  logic                  term_rx_en,
    output var  logic                  out_edge
);
    import dca_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int SW = ADDR_W + BANK_W + 7;
    logic [SW-1:0] sync_in;
    logic [SW-1:0] sync_out;

    assign sync_in = {clock_true, clock_comp, clk_en, chip_sel_n, row_strobe_n,
                      col_strobe_n, write_en_n, bank_sel, addr};

    dca_sync #(.WIDTH(SW)) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   (sync_in),
        .pin_sync (sync_out)
    );

    wire                  s_ck    = sync_out[SW-1];
    wire                  s_ckc   = sync_out[SW-2];
    wire                  s_cke   = sync_out[SW-3];
    wire                  s_cs_n  = sync_out[SW-4];
    wire [2:0]            s_code  = sync_out[SW-5 -: 3];
    wire [BANK_W-1:0]     s_bank  = sync_out[ADDR_W +: BANK_W];
    wire [ADDR_W-1:0]     s_addr  = sync_out[ADDR_W-1:0];

    // ------------------------------------------------------------
    // Clock crossing detection
    // ------------------------------------------------------------
    logic ck_q;
    logic ckc_q;
    logic cke_reg_q;
    logic cke_reg_d;

    // Positive edge: true rises while complement falls
    wire pos_edge = s_ck & ~ck_q & ~s_ckc & ckc_q;
    wire any_edge = (s_ck ^ ck_q) & (s_ckc ^ ckc_q);

    // Self-refresh exit does not wait for a clock edge
    wire sr_exit  = (pwr_state == DCA_PWR_SELF) & s_cke;

    assign cke_reg_d = pos_edge ? s_cke : (sr_exit ? 1'b1 : cke_reg_q);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire      sel     = pos_edge & ~s_cs_n & cmd_rx_en;
    wire      run     = sel & s_cke & cke_reg_q;
    wire      is_act  = run & (s_code == CODE_ACTIVATE);
    wire      is_rd   = run & (s_code == CODE_READ);
    wire      is_wr   = run & (s_code == CODE_WRITE);
    wire      is_pre  = run & (s_code == CODE_PRECHARGE);
    wire      is_ref  = run & (s_code == CODE_REFRESH);
    wire      is_sre  = sel & ~s_cke & cke_reg_q & (s_code == CODE_REFRESH);
    wire      mode_ok = s_bank <= SEL_EXTENDED_MODE_REG_THREE;
    wire      is_mrs  = run & (s_code == CODE_LOAD_MODE) & mode_ok;
    wire      ap_bit  = s_addr[AP_BIT];
    wire      all_idle = (bank_open == '0);

    dca_cmd_t cmd_d;
    assign cmd_d = is_act ? DCA_CMD_ACTIVATE  :
                   is_rd  ? DCA_CMD_READ      :
                   is_wr  ? DCA_CMD_WRITE     :
                   is_pre ? DCA_CMD_PRECHARGE :
                   is_ref ? DCA_CMD_REFRESH   :
                   is_mrs ? DCA_CMD_LOAD_MODE :
                   is_sre ? DCA_CMD_SELF_REF  : DCA_CMD_NONE;

    // Column excludes the auto-precharge bit
    logic [ADDR_W-1:0] col_mask;
    always_comb
    begin
        col_mask         = s_addr;
        col_mask[AP_BIT] = 1'b0;
    end

    // ------------------------------------------------------------
    // Bank open tracking
    // ------------------------------------------------------------
    logic [NUM_BANKS-1:0] bank_d;
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++)
        begin : g_bank
            wire hit = (s_bank == BANK_W'(b));
            assign bank_d[b] = (is_act & hit) ? 1'b1 :
                               (is_pre & (ap_bit | hit)) ? 1'b0 :
                               ((is_rd | is_wr) & ap_bit & hit) ? 1'b0 :
                               bank_open[b];
        end
    endgenerate

    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    dca_pwr_t pwr_d;
    always_comb
    begin
        pwr_d = pwr_state;
        case (pwr_state)
            DCA_PWR_ACTIVE:
                if (is_sre)
                    pwr_d = DCA_PWR_SELF;
                else if (pos_edge & ~s_cke & cke_reg_q)
                    pwr_d = all_idle ? DCA_PWR_PREC_PD : DCA_PWR_ACT_PD;
            DCA_PWR_PREC_PD, DCA_PWR_ACT_PD:
                if (pos_edge & s_cke)
                    pwr_d = DCA_PWR_ACTIVE;
            DCA_PWR_SELF:
                if (sr_exit)
                    pwr_d = DCA_PWR_ACTIVE;
            default:
                pwr_d = DCA_PWR_ACTIVE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ck_q      <= 1'b0;
            ckc_q     <= 1'b1;
            cke_reg_q <= 1'b0;
            pwr_state <= DCA_PWR_ACTIVE;
            bank_open <= '0;
        end
        else
        begin
            ck_q      <= s_ck;
            ckc_q     <= s_ckc;
            cke_reg_q <= cke_reg_d;
            pwr_state <= pwr_d;
            bank_open <= bank_d;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cmd_valid     <= 1'b0;
            cmd           <= DCA_CMD_NONE;
            cmd_bank      <= '0;
            cmd_row       <= '0;
            cmd_col       <= '0;
            cmd_auto_pre  <= 1'b0;
            cmd_all_banks <= 1'b0;
        end
        else
        begin
            cmd_valid     <= (cmd_d != DCA_CMD_NONE);
            cmd           <= cmd_d;
            cmd_bank      <= s_bank;
            cmd_row       <= is_act ? s_addr : '0;
            cmd_col       <= (is_rd | is_wr) ? col_mask : '0;
            cmd_auto_pre  <= (is_rd | is_wr) & ap_bit;
            cmd_all_banks <= is_pre & ap_bit;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mode_wr     <= 1'b0;
            mode_sel    <= 2'h0;
            mode_opcode <= '0;
        end
        else
        begin
            mode_wr     <= is_mrs;
            mode_sel    <= s_bank[1:0];
            mode_opcode <= is_mrs ? s_addr : mode_opcode;
        end
    end

    // Receiver enables; command receivers return only once fully active
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            int_clk_en <= 1'b0;
            cmd_rx_en  <= 1'b1;
            term_rx_en <= 1'b1;
            out_edge   <= 1'b0;
        end
        else
        begin
            int_clk_en <= cke_reg_d;
            cmd_rx_en  <= (pwr_d == DCA_PWR_ACTIVE);
            term_rx_en <= (pwr_d != DCA_PWR_SELF);
            out_edge   <= any_edge & int_clk_en;
        end
    end
endmodule
`default_nettype wire

// File: rtl/dca_pkg.sv
// Package: constants and types for the DRAM command/address input stage
`default_nettype none
package dca_pkg;
    localparam int ADDR_W_X8  = 14;
    localparam int ADDR_W_X16 = 13;
    localparam int BANK_W     = 3;
    localparam int NUM_BANKS  = 8;
    localparam int AP_BIT     = 10;
    localparam int SYNC_DEPTH = 2;

    // Command code {row_strobe_n, col_strobe_n, write_en_n}
    localparam logic [2:0] CODE_LOAD_MODE = 3'h0;
    localparam logic [2:0] CODE_REFRESH   = 3'h1;
    localparam logic [2:0] CODE_PRECHARGE = 3'h2;
    localparam logic [2:0] CODE_ACTIVATE  = 3'h3;
    localparam logic [2:0] CODE_WRITE     = 3'h4;
    localparam logic [2:0] CODE_READ      = 3'h5;
    localparam logic [2:0] CODE_NOP       = 3'h7;

    // Mode register select values on the bank inputs
    localparam logic [2:0] SEL_BASE_MODE_REG        = 3'h0;
    localparam logic [2:0] SEL_EXTENDED_MODE_REG    = 3'h1;
    localparam logic [2:0] SEL_EXTENDED_MODE_REG_TWO = 3'h2;
    localparam logic [2:0] SEL_EXTENDED_MODE_REG_THREE = 3'h3;

    typedef enum logic [2:0] {
        DCA_CMD_NONE      = 3'h0,
        DCA_CMD_ACTIVATE  = 3'h1,
        DCA_CMD_READ      = 3'h2,
        DCA_CMD_WRITE     = 3'h3,
        DCA_CMD_PRECHARGE = 3'h4,
        DCA_CMD_REFRESH   = 3'h5,
        DCA_CMD_LOAD_MODE = 3'h6,
        DCA_CMD_SELF_REF  = 3'h7
    } dca_cmd_t;

    // Gray sequence along idle -> power-down -> self refresh
    typedef enum logic [1:0] {
        DCA_PWR_ACTIVE  = 2'h0,
        DCA_PWR_PREC_PD = 2'h1,
        DCA_PWR_ACT_PD  = 2'h3,
        DCA_PWR_SELF    = 2'h2
    } dca_pwr_t;
endpackage
`default_nettype wire

// File: rtl/dca_sync.sv
// Two-flop synchroniser bank for pin inputs
`default_nettype none
module dca_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Data
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge core_clk)
            begin
                if (sys_rst)
                begin
                    meta_q[i]   <= 1'b0;
                    pin_sync[i] <= 1'b0;
                end
                else
                begin
                    meta_q[i]   <= pin_in[i];
                    pin_sync[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// File: test/dca_input_stage_asserts.sv
// Checker: port-level properties of the command/address input stage
`default_nettype none
module dca_input_stage_asserts
    import dca_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_X8
) (
    input wire logic              core_clk,
    input wire logic              sys_rst,
    input wire logic              clock_true,
    input wire logic              clock_comp,
    input wire logic              clk_en,
    input wire logic              chip_sel_n,
    input wire logic              row_strobe_n,
    input wire logic              col_strobe_n,
    input wire logic              write_en_n,
    input wire logic [BANK_W-1:0] bank_sel,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              cmd_valid,
    input wire dca_cmd_t          cmd,
    input wire logic [BANK_W-1:0] cmd_bank,
    input wire logic [ADDR_W-1:0] cmd_row,
    input wire logic [ADDR_W-1:0] cmd_col,
    input wire logic              cmd_auto_pre,
    input wire logic              cmd_all_banks,
    input wire logic              mode_wr,
    input wire logic [1:0]        mode_sel,
    input wire logic [ADDR_W-1:0] mode_opcode,
    input wire logic [7:0]        bank_open,
    input wire dca_pwr_t          pwr_state,
    input wire logic              cmd_rx_en,
    input wire logic              term_rx_en
);
    // Column keeps every address bit except the auto-precharge flag
    localparam logic [ADDR_W-1:0] COL_MASK = ~(ADDR_W'(1) << AP_BIT);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_cs_gate: assert property ((cmd_valid || mode_wr) |-> !chip_sel_n)
        else $error("command decoded with chip select high");
    chk_rising_only: assert property ($rose(cmd_valid) |-> clock_true && !clock_comp)
        else $error("command not tied to the true clock rising");
    chk_col_flag: assert property (cmd_valid && cmd inside {DCA_CMD_READ, DCA_CMD_WRITE}
        |-> cmd_auto_pre == addr[AP_BIT] && cmd_col == (addr & COL_MASK) && cmd_bank == bank_sel)
        else $error("read or write column, flag or bank wrong");
    chk_act_row: assert property (cmd_valid && cmd == DCA_CMD_ACTIVATE
        |-> cmd_row == addr && cmd_bank == bank_sel
            && {row_strobe_n, col_strobe_n, write_en_n} == CODE_ACTIVATE)
        else $error("activate row, bank or code wrong");
    chk_pre_scope: assert property (cmd_valid && cmd == DCA_CMD_PRECHARGE
        |-> cmd_all_banks == addr[AP_BIT] ##[0:1] (!addr[AP_BIT] || bank_open == 8'h00))
        else $error("precharge scope wrong");
    chk_mode_sel: assert property (mode_wr |-> !bank_sel[2] && mode_sel == bank_sel[1:0]
        ##[0:1] mode_opcode == addr)
        else $error("mode load select or opcode wrong");
    chk_self_exit: assert property (pwr_state == DCA_PWR_SELF && clk_en
        |-> ##[1:5] pwr_state != DCA_PWR_SELF)
        else $error("self refresh not left on clock enable");
    chk_rx_gate: assert property (pwr_state != DCA_PWR_ACTIVE && $stable(pwr_state)
        |-> !cmd_rx_en && term_rx_en == (pwr_state != DCA_PWR_SELF))
        else $error("receiver enables wrong in low power");
    chk_pd_kind: assert property (pwr_state inside {DCA_PWR_PREC_PD, DCA_PWR_ACT_PD}
        |-> (bank_open != 8'h00) == (pwr_state == DCA_PWR_ACT_PD))
        else $error("power-down kind does not match open banks");
endmodule
bind dca_input_stage dca_input_stage_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// File: test/dca_ctl_model.sv
// Controller model: link clock, clock enable, command and address pins
`default_nettype none
module dca_ctl_model
    import dca_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_X8
) (
    // Core clock places pin changes
    input  wire logic              core_clk,
    // Pins toward the device
    output var  logic              clock_true,
    output var  logic              clock_comp,
    output var  logic              clk_en,
    output var  logic              chip_sel_n,
    output var  logic              row_strobe_n,
    output var  logic              col_strobe_n,
    output var  logic              write_en_n,
    output var  logic [BANK_W-1:0] bank_sel,
    output var  logic [ADDR_W-1:0] addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        clock_true = 1'b0;
        clock_comp = 1'b1;
        clk_en = 1'b1;
        chip_sel_n = 1'b1;
        {row_strobe_n, col_strobe_n, write_en_n} = CODE_NOP;
        bank_sel = 3'h0;
        addr = '0;
    end
    // One 125 ns link period; the clock stands still between frames
    task automatic frame(input logic cke, input logic cs_n, input logic [2:0] code,
                         input logic [BANK_W-1:0] ba, input logic [ADDR_W-1:0] a);
        @(posedge core_clk) #1;
        clk_en = cke;
        chip_sel_n = cs_n;
        {row_strobe_n, col_strobe_n, write_en_n} = code;
        bank_sel = ba;
        addr = a;
        #31.25 clock_true = 1'b1;
        clock_comp = 1'b0;
        #62.5 clock_true = 1'b0;
        clock_comp = 1'b1;
        // Finish the low half before the pins move, so the falling crossing is seen first
        #31.25;
        @(posedge core_clk) #1;
        // Deselect when idle; released lines show the inverse, not the old value
        chip_sel_n = 1'b1;
        {row_strobe_n, col_strobe_n, write_en_n} = CODE_NOP;
        bank_sel = ~ba;
        addr = ~a;
    endtask
    task automatic set_cke(input logic v);
        @(posedge core_clk) #1;
        clk_en = v;
    endtask
endmodule
`default_nettype wire

// File: test/dca_input_stage_tb_top.sv
// Testbench for the command/address input stage
`default_nettype none
module dca_input_stage_tb_top;
    import dca_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, sys_rst = 1'b1, termination_control = 1'b0;
    logic clock_true, clock_comp, clk_en, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n;
    logic [2:0] bank_sel, cmd_bank, l_cmd, l_bank;
    logic [13:0] addr, cmd_row, cmd_col, mode_opcode, l_row, l_col;
    logic [1:0] mode_sel, l_sel;
    logic [7:0] bank_open;
    logic cmd_valid, cmd_auto_pre, cmd_all_banks, mode_wr, int_clk_en;
    logic cmd_rx_en, term_rx_en, out_edge, l_ap, l_all;
    dca_cmd_t cmd;
    dca_pwr_t pwr_state;
    int err_count = 0, checks_done = 0, n_cmd = 0, n_mode = 0, n_edge = 0, cyc = 0;

    dca_input_stage i_dut (.*);
    dca_ctl_model i_ctl (.*);
    always #4 core_clk = ~core_clk;

    // ----------------------------------------
    // Capture of decoded pulses, hang guard
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cmd_valid === 1'b1)
            {n_cmd, l_cmd, l_bank, l_row, l_col, l_ap, l_all} <=
                {n_cmd + 1, cmd, cmd_bank, cmd_row, cmd_col, cmd_auto_pre, cmd_all_banks};
        if (mode_wr === 1'b1)
            {n_mode, l_sel} <= {n_mode + 1, mode_sel};
        if (out_edge === 1'b1)
            n_edge <= n_edge + 1;
        if (cyc == 6000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic f(input logic cke, cs_n, input logic [2:0] c, b, input logic [13:0] a);
        i_ctl.frame(cke, cs_n, c, b, a);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_rw;
        int n;
        int e;
        f(1, 1, CODE_NOP, 0, 0);
        n = n_cmd;
        e = n_edge;
        f(1, 0, CODE_ACTIVATE, 5, 14'h2a5c);
        chk("edges", e + 2, n_edge);
        chk("cmd", DCA_CMD_ACTIVATE, l_cmd);
        chk("row", 14'h2a5c, l_row);
        chk("open", 8'h20, bank_open);
        f(1, 0, CODE_READ, 5, 14'h03ff);
        chk("col", {1'b0, 3'h5, 14'h03ff}, {l_ap, l_bank, l_col});
        f(1, 0, CODE_WRITE, 5, 14'h3c04);
        chk("col", {1'b1, 3'h5, 14'h3804}, {l_ap, l_bank, l_col});
        chk("open", 8'h00, bank_open);
        f(1, 0, CODE_REFRESH, 0, 14'h0000);
        chk("cmd", DCA_CMD_REFRESH, l_cmd);
        chk("count", n + 4, n_cmd);
        $display("test rw done");
    endtask
    task automatic t_cs;
        int n;
        n = n_cmd;
        f(1, 1, CODE_ACTIVATE, 2, 0);
        chk("count", n, n_cmd);
        chk("open", 8'h00, bank_open);
        $display("test cs done");
    endtask
    task automatic t_pre;
        f(1, 0, CODE_ACTIVATE, 1, 0);
        f(1, 0, CODE_ACTIVATE, 2, 0);
        f(1, 0, CODE_PRECHARGE, 1, 14'h3bff);
        chk("open", 8'h04, bank_open);
        chk("all", 0, l_all);
        f(1, 0, CODE_PRECHARGE, 6, 14'h0400);
        chk("open", 8'h00, bank_open);
        chk("all", 1, l_all);
        $display("test pre done");
    endtask
    task automatic t_mode;
        int n;
        for (int s = 0; s < 5; s++)
        begin
            n = n_mode;
            f(1, 0, CODE_LOAD_MODE, 3'(s), 14'h1230 + 14'(s));
            chk("mode count", n + int'(s < 4), n_mode);
            if (s < 4)
            begin
                chk("mode", {2'(s), 14'h1230 + 14'(s)}, {l_sel, mode_opcode});
                chk("cmd", DCA_CMD_LOAD_MODE, l_cmd);
            end
        end
        $display("test mode done");
    endtask
    task automatic t_pwr;
        f(0, 1, CODE_NOP, 0, 0);
        chk("pwr", {DCA_PWR_PREC_PD, 2'b01}, {pwr_state, cmd_rx_en, term_rx_en});
        chk("clk on", 1'b0, int_clk_en);
        f(1, 1, CODE_NOP, 0, 0);
        chk("pwr", DCA_PWR_ACTIVE, pwr_state);
        chk("clk on", 1'b1, int_clk_en);
        f(1, 0, CODE_ACTIVATE, 3, 0);
        f(0, 1, CODE_NOP, 0, 0);
        chk("pwr", DCA_PWR_ACT_PD, pwr_state);
        f(0, 0, CODE_ACTIVATE, 4, 0);
        chk("open", 8'h08, bank_open);
        f(1, 1, CODE_NOP, 0, 0);
        f(1, 0, CODE_PRECHARGE, 0, 14'h0400);
        f(0, 0, CODE_REFRESH, 0, 0);
        chk("pwr", {DCA_PWR_SELF, 2'b00}, {pwr_state, cmd_rx_en, term_rx_en});
        chk("cmd", DCA_CMD_SELF_REF, l_cmd);
        i_ctl.set_cke(1);
        repeat (6) @(posedge core_clk);
        #1;
        chk("pwr", DCA_PWR_ACTIVE, pwr_state);
        f(1, 1, CODE_NOP, 0, 0);
        $display("test pwr done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        t_rw();
        t_cs();
        t_pre();
        t_mode();
        t_pwr();
        tally_and_finish();
    end
endmodule
`default_nettype wire
